// [verilog/ltc_defines.svh]
// Register map, field positions and constants of the tick counter
// -----------------------------------------------------------------------------
// Function
// R1: A 16-bit count advances on every prescaled reference clock rising edge.
// R2: A 3-bit divider code stops the count or divides by 1 to 1024.
// R3: Count equal to match value raises a compare condition, interrupt and event.
// R4: Count equal to top value raises overflow, interrupt and event, and clears count.
// R5: Events come every third condition at top 0, every second at top 1.
// R6: Compare flag is set on the count after the match.
// R7: Compare flag clears on its vector acknowledge or on a written one.
// R8: Overflow flag sets on the next count; clears on acknowledge or written one.
// R9: Compare level field enables the compare request, which follows the compare flag.
// R10: Overflow level field enables the overflow request, which follows the flag.
// R11: A read-only busy bit shows a count, control or match write still settling.
// R12: Count, top and match writes take effect two reference cycles after writing.
// R13: Software waits for the busy bit to read zero before such writes.
// R14: Staging byte holds a written low byte and captures high on low read.
// R15: A match value above the top value never yields compare requests or events.
// R16: Unused upper bits of status and flag registers read as zero.
// R17: Software writes zeros into every reserved bit position.
// R18: High byte write commits both bytes at once; high read returns staging byte.
// R19: Conditions reach the flags only through the reference edge sampling path.
// -----------------------------------------------------------------------------
`ifndef LTC_DEFINES_SVH
`define LTC_DEFINES_SVH

`define LTC_AW          4
`define LTC_DW          8
`define LTC_CW          16
`define LTC_PW          10

`define LTC_A_CTRL      4'h0
`define LTC_A_STATUS    4'h1
`define LTC_A_ILVL      4'h2
`define LTC_A_FLAGS     4'h3
`define LTC_A_TEMP      4'h4
`define LTC_A_COUNT_LOW      4'h8
`define LTC_A_COUNT_HIGH      4'h9
`define LTC_A_TOPL      4'ha
`define LTC_A_TOPH      4'hb
`define LTC_A_CMPL      4'hc
`define LTC_A_CMPH      4'hd

`define LTC_F_WRAP      0
`define LTC_F_MATCH     1
`define LTC_P_CNT       0
`define LTC_P_TOP       1
`define LTC_P_CMP       2
`define LTC_P_CTL       3

`define LTC_SYNC_EDGES  2'h2
`define LTC_TOP_RESET   16'hffff

`endif

// [verilog/ltc_pkg.sv]
// Types of the tick counter
package ltc_pkg;

  typedef struct packed {
    logic [2:0]  ctl;
    logic [2:0]  ctl_sh;
    logic [15:0] cnt;
    logic [15:0] cnt_sh;
    logic [15:0] top;
    logic [15:0] top_sh;
    logic [15:0] cmp;
    logic [15:0] cmp_sh;
    logic [3:0]  pend;
    logic [1:0]  sync;
    logic [3:0]  ilvl;
    logic [1:0]  flags;
    logic [1:0]  cond;
    logic [1:0]  mthin;
    logic [1:0]  wthin;
    logic [7:0]  temp;
    logic [9:0]  pre;
    logic        ref_prev;
    logic [7:0]  rdata;
    logic        mreq;
    logic        wreq;
    logic        mevt;
    logic        wevt;
    logic        irq;
  } ltc_state_t;

endpackage : ltc_pkg

// [verilog/ltc_top.sv]
// Low power tick counter with prescaler, top and match compare
`timescale 1ns/1ps
`include "ltc_defines.svh"

module ltc_top (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ref_clk_in,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       match_ack,
  input  wire logic       wrap_ack,
  output logic            match_irq_req,
  output logic            wrap_irq_req,
  output logic      [1:0] match_irq_level,
  output logic      [1:0] wrap_irq_level,
  output logic            irq,
  output logic            match_evt,
  output logic            wrap_evt
);

  ltc_pkg::ltc_state_t s_q;
  ltc_pkg::ltc_state_t s_d;

  // -----------------------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------------------
  // Prescaler mask: tick when all masked bits of the edge counter are ones
  function automatic logic [9:0] div_mask(input logic [2:0] code);
    case (code)
      3'h2:    div_mask = 10'h001;
      3'h3:    div_mask = 10'h007;
      3'h4:    div_mask = 10'h00f;
      3'h5:    div_mask = 10'h03f;
      3'h6:    div_mask = 10'h0ff;
      3'h7:    div_mask = 10'h3ff;
      default: div_mask = 10'h000;
    endcase
  endfunction : div_mask

  // Event thinning limit from the top value
  function automatic logic [1:0] thin_lim(input logic [15:0] top);
    if (top == 16'h0000) begin
      thin_lim = 2'h3;
    end else if (top == 16'h0001) begin
      thin_lim = 2'h2;
    end else begin
      thin_lim = 2'h1;
    end
  endfunction : thin_lim

  // -----------------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------------
  always_comb begin
    logic       ref_edge;
    logic       tick;
    logic [1:0] clr;
    logic [1:0] set;
    logic [1:0] lim;
    ref_edge = 1'b0;
    tick     = 1'b0;
    clr      = 2'h0;
    set      = 2'h0;
    lim      = 2'h0;
    s_d      = s_q;
    s_d.mevt = 1'b0;
    s_d.wevt = 1'b0;

    // Reference clock is sampled; its rising edge is one system cycle
    ref_edge   = ref_clk_in & ~s_q.ref_prev;
    s_d.ref_prev = ref_clk_in;

    // Writes cross on reference edges; busy holds until the second one
    if (ref_edge && s_q.pend != 4'h0) begin
      if (s_q.sync == `LTC_SYNC_EDGES - 2'h1) begin  // [R12]
        if (s_q.pend[`LTC_P_CTL]) s_d.ctl = s_q.ctl_sh;
        if (s_q.pend[`LTC_P_TOP]) s_d.top = s_q.top_sh;
        if (s_q.pend[`LTC_P_CMP]) s_d.cmp = s_q.cmp_sh;
        s_d.pend = 4'h0;
        s_d.sync = 2'h0;
      end else begin
        s_d.sync = s_q.sync + 2'h1;
      end
    end

    // Prescaler: code 0 stops the prescaler and the count
    if (ref_edge && s_q.ctl != 3'h0) begin  // [R2]
      s_d.pre = s_q.pre + 10'h001;
      tick    = (s_q.pre & div_mask(s_q.ctl)) == div_mask(s_q.ctl);
    end

    if (tick) begin
      // Conditions found on this count show on the next count
      set = s_q.cond;  // [R6] [R8] [R19]
      if (s_q.cond[`LTC_F_MATCH]) begin
        lim = thin_lim(s_q.top);
        if (s_q.mthin + 2'h1 >= lim) begin  // [R5]
          s_d.mthin = 2'h0;
          s_d.mevt  = 1'b1;
        end else begin
          s_d.mthin = s_q.mthin + 2'h1;
        end
      end
      if (s_q.cond[`LTC_F_WRAP]) begin
        lim = thin_lim(s_q.top);
        if (s_q.wthin + 2'h1 >= lim) begin  // [R5]
          s_d.wthin = 2'h0;
          s_d.wevt  = 1'b1;
        end else begin
          s_d.wthin = s_q.wthin + 2'h1;
        end
      end
      s_d.cond[`LTC_F_MATCH] = (s_q.cnt == s_q.cmp) && (s_q.cmp <= s_q.top);  // [R3] [R15]
      s_d.cond[`LTC_F_WRAP]  = (s_q.cnt == s_q.top);  // [R4]
      s_d.cnt = (s_q.cnt == s_q.top) ? 16'h0000 : s_q.cnt + 16'h0001;  // [R1] [R4]
    end

    // A pending count write overrides counting on its commit edge
    if (ref_edge && s_q.pend[`LTC_P_CNT] && s_q.sync == `LTC_SYNC_EDGES - 2'h1) begin
      s_d.cnt = s_q.cnt_sh;  // [R12]
    end

    // Register writes; reserved bits are dropped
    if (wr) begin
      if (addr == `LTC_A_CTRL) begin
        s_d.ctl_sh = wdata[2:0];
        s_d.pend[`LTC_P_CTL] = 1'b1;  // [R11]
        s_d.sync = 2'h0;
      end else if (addr == `LTC_A_ILVL) begin
        s_d.ilvl = wdata[3:0];
      end else if (addr == `LTC_A_FLAGS) begin
        clr = wdata[1:0];  // [R7] [R8]
      end else if (addr == `LTC_A_TEMP || addr == `LTC_A_COUNT_LOW ||
                   addr == `LTC_A_TOPL || addr == `LTC_A_CMPL) begin
        s_d.temp = wdata;  // [R14]
      end else if (addr == `LTC_A_COUNT_HIGH) begin
        s_d.cnt_sh = {wdata, s_q.temp};  // [R18]
        s_d.pend[`LTC_P_CNT] = 1'b1;  // [R11]
        s_d.sync = 2'h0;
      end else if (addr == `LTC_A_TOPH) begin
        s_d.top_sh = {wdata, s_q.temp};  // [R18]
        s_d.pend[`LTC_P_TOP] = 1'b1;
        s_d.sync = 2'h0;
      end else if (addr == `LTC_A_CMPH) begin
        s_d.cmp_sh = {wdata, s_q.temp};  // [R18]
        s_d.pend[`LTC_P_CMP] = 1'b1;  // [R11]
        s_d.sync = 2'h0;
      end
    end

    // Register reads, data one cycle later; unmapped reads zero
    s_d.rdata = 8'h00;
    if (rd) begin
      if (addr == `LTC_A_CTRL) begin
        s_d.rdata = {5'h00, s_q.ctl_sh};
      end else if (addr == `LTC_A_STATUS) begin
        s_d.rdata = {7'h00, s_q.pend != 4'h0};  // [R11] [R16]
      end else if (addr == `LTC_A_ILVL) begin
        s_d.rdata = {4'h0, s_q.ilvl};
      end else if (addr == `LTC_A_FLAGS) begin
        s_d.rdata = {6'h00, s_q.flags};  // [R16]
      end else if (addr == `LTC_A_TEMP) begin
        s_d.rdata = s_q.temp;
      end else if (addr == `LTC_A_COUNT_LOW) begin
        s_d.rdata = s_q.cnt[7:0];
        s_d.temp  = s_q.cnt[15:8];  // [R14]
      end else if (addr == `LTC_A_TOPL) begin
        s_d.rdata = s_q.top_sh[7:0];
        s_d.temp  = s_q.top_sh[15:8];  // [R14]
      end else if (addr == `LTC_A_CMPL) begin
        s_d.rdata = s_q.cmp_sh[7:0];
        s_d.temp  = s_q.cmp_sh[15:8];  // [R14]
      end else if (addr == `LTC_A_COUNT_HIGH || addr == `LTC_A_TOPH ||
                   addr == `LTC_A_CMPH) begin
        s_d.rdata = s_q.temp;  // [R18]
      end
    end

    // Vector acknowledge clears too; a new set wins over any clear
    clr[`LTC_F_MATCH] = clr[`LTC_F_MATCH] | match_ack;  // [R7]
    clr[`LTC_F_WRAP]  = clr[`LTC_F_WRAP] | wrap_ack;  // [R8]
    s_d.flags = (s_q.flags & ~clr) | set;

    s_d.mreq = s_d.flags[`LTC_F_MATCH] && s_d.ilvl[3:2] != 2'h0;  // [R9]
    s_d.wreq = s_d.flags[`LTC_F_WRAP] && s_d.ilvl[1:0] != 2'h0;  // [R10]
    s_d.irq  = s_d.mreq | s_d.wreq;
  end

  // -----------------------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q        <= '0;
      s_q.top    <= `LTC_TOP_RESET;
      s_q.top_sh <= `LTC_TOP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata           = s_q.rdata;
  assign match_irq_req   = s_q.mreq;
  assign wrap_irq_req    = s_q.wreq;
  assign match_irq_level = s_q.ilvl[3:2];
  assign wrap_irq_level  = s_q.ilvl[1:0];
  assign irq             = s_q.irq;
  assign match_evt       = s_q.mevt;
  assign wrap_evt        = s_q.wevt;

endmodule : ltc_top

// [verif/ltc_top_assertions.sv]
// Port checker of the tick counter
`timescale 1ns/1ps
module ltc_chk (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       match_ack,
  input wire logic       match_irq_req,
  input wire logic       wrap_irq_req,
  input wire logic [1:0] match_irq_level,
  input wire logic [1:0] wrap_irq_level,
  input wire logic       irq,
  input wire logic       match_evt,
  input wire logic       wrap_evt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] lv_q;
  always_ff @(posedge clk) if (wr && addr == 4'h2) lv_q <= wdata;
  sequence s_lvl_wr;
    wr && addr == 4'h2;
  endsequence
  property p_lvl;
    s_lvl_wr |-> ##[1:2] {match_irq_level, wrap_irq_level} == lv_q[3:0];
  endproperty
  property p_mevt; match_evt |=> !match_evt; endproperty
  property p_wevt; wrap_evt |=> !wrap_evt; endproperty
  property p_mreq; match_irq_req |-> match_irq_level != 2'h0 || $past(match_irq_level) != 2'h0;
  endproperty
  property p_wreq; wrap_irq_req |-> wrap_irq_level != 2'h0 || $past(wrap_irq_level) != 2'h0;
  endproperty
  property p_irq; (match_irq_req || wrap_irq_req) |-> ##[0:1] irq; endproperty
  property p_ack; match_ack |-> ##[1:3] !match_irq_req; endproperty
  property p_rsvd; rd && addr == 4'h1 |=> rdata[7:1] == 7'h00; endproperty
  a_lvl: assert property (p_lvl) else $error("level outputs differ from write");
  a_mevt: assert property (p_mevt) else $error("match event too long");
  a_wevt: assert property (p_wevt) else $error("wrap event too long");
  a_mreq: assert property (p_mreq) else $error("match request with level 0");
  a_wreq: assert property (p_wreq) else $error("wrap request with level 0");
  a_irq: assert property (p_irq) else $error("irq missing");
  a_ack: assert property (p_ack) else $error("ack left match request");
  a_rsvd: assert property (p_rsvd) else $error("status reserved bits set");
endmodule : ltc_chk

bind ltc_top ltc_chk ltc_chk_inst (.*);

// [verif/tb_top.sv]
// Self-checking bench of the tick counter
`timescale 1ns/1ps
`include "ltc_defines.svh"
module tb_top;
  logic        clk, rst_n, wr, rd, match_ack, wrap_ack;
  logic        ref_clk_in = 1'b0;
  logic        match_irq_req, wrap_irq_req, irq, match_evt, wrap_evt;
  logic  [1:0] match_irq_level, wrap_irq_level;
  logic  [3:0] addr;
  logic  [7:0] wdata, rdata, rv;
  logic [15:0] v16, x16;
  int          n_fail, compares, cyc, refs, nm, t0, t1, lv;
  int          divs[8] = '{0, 1, 2, 8, 16, 64, 256, 1024};
  int          cs[9][2] = '{'{0,1}, '{1,1}, '{2,2}, '{5,1}, '{2,3}, '{2,4}, '{2,5}, '{2,6}, '{2,7}};
  logic  [3:0] ra[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'h5};

  ltc_top ltc_top_inst (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Reference at a quarter of clk, wide enough for edge sampling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 2 == 1) ref_clk_in <= ~ref_clk_in;
    if (cyc % 2 == 1 && !ref_clk_in) refs <= refs + 1;
    if (match_evt === 1'b1) nm <= nm + 1;
    if (cyc == 90000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #10 d = rdata;
  endtask : rd_reg

  task automatic rd16(logic [3:0] a, output logic [15:0] v);
    rd_reg(a, v[7:0]);
    rd_reg(a + 4'h1, v[15:8]);
  endtask : rd16

  task automatic idle();
    repeat (40) begin
      rd_reg(`LTC_A_STATUS, rv);
      if (rv[0] === 1'b0) return;
    end
    chk("sync busy", 16'h0, 16'h1);
  endtask : idle

  task automatic wr16(logic [3:0] a, logic [15:0] v);
    idle();
    wr_reg(a, v[7:0]);
    wr_reg(a + 4'h1, v[15:8]);
  endtask : wr16

  // Stop and clear first so a smaller top never strands the count above it
  task automatic cfg(int top, int cmp, int code);
    wr_reg(`LTC_A_CTRL, 8'h00);
    wr16(`LTC_A_COUNT_LOW, 16'h0);
    wr16(`LTC_A_TOPL, top[15:0]);
    wr16(`LTC_A_CMPL, cmp[15:0]);
    idle();
    wr_reg(`LTC_A_CTRL, code[7:0]);
    idle();
  endtask : cfg

  task automatic wait_evt(bit m, output int r);
    r = -1;
    repeat (30000) begin
      @(posedge clk);
      if ((m ? match_evt : wrap_evt) === 1'b1) begin
        r = refs;
        return;
      end
    end
    // Missing event counts as a mismatch
    n_fail++;
  endtask : wait_evt

  initial begin
    {rst_n, wr, rd, match_ack, wrap_ack} = 5'h0;
    addr = 4'h0;
    wdata = 8'h0;
    t0 = $urandom(32'h3f8f7fe2);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr_reg(4'h5, 8'h5a);
    foreach (ra[i]) begin
      rd_reg(ra[i], rv);
      chk("reset read", 16'h0, {8'h0, rv});
    end
    rd16(`LTC_A_TOPL, v16);
    chk("top reset", `LTC_TOP_RESET, v16);
    repeat (4) begin
      x16 = 16'($urandom);
      wr16(`LTC_A_CMPL, x16);
      rd_reg(`LTC_A_TEMP, rv);
      chk("staged low", {8'h0, x16[7:0]}, {8'h0, rv});
      rd16(`LTC_A_CMPL, v16);
      chk("match readback", x16, v16);
    end
    $display("register test done");
    foreach (cs[i]) begin
      cfg(cs[i][0], cs[i][0], cs[i][1]);
      lv = (cs[i][0] + 1) * (cs[i][0] == 0 ? 3 : cs[i][0] == 1 ? 2 : 1) * divs[cs[i][1]];
      // First event may come from a condition left by the previous setup
      wait_evt(i < 4, t0);
      wait_evt(i < 4, t0);
      wait_evt(i < 4, t1);
      chk("event interval", 16'(lv), 16'(t1 - t0));
    end
    $display("prescaler test done");
    lv = $urandom_range(1, 3);
    cfg(99, 4, 1);
    wr_reg(`LTC_A_ILVL, 8'(lv * 5));
    wait_evt(0, t0);
    wait_evt(1, t1);
    chk("match offset", 16'd5, 16'(t1 - t0));
    rd_reg(`LTC_A_FLAGS, rv);
    chk("flags", 16'h3, {8'h0, rv});
    chk("levels", 16'(lv * 5), {12'h0, match_irq_level, wrap_irq_level});
    @(posedge clk) match_ack <= 1'b1;
    @(posedge clk) match_ack <= 1'b0;
    wr_reg(`LTC_A_FLAGS, 8'h01);
    rd_reg(`LTC_A_FLAGS, rv);
    chk("flags cleared", 16'h0, {8'h0, rv});
    chk("requests idle", 16'h0, {13'h0, irq, match_irq_req, wrap_irq_req});
    wr_reg(`LTC_A_ILVL, 8'h01);
    wait_evt(1, t0);
    repeat (3) @(posedge clk);
    chk("masked request", 16'h1, {14'h0, match_irq_req, wrap_irq_req});
    $display("interrupt test done");
    cfg(9, 10, 1);
    t1 = nm;
    wait_evt(0, t0);
    wait_evt(0, t0);
    chk("match events", 16'(t1), 16'(nm));
    $display("match above top test done");
    close_out();
  end
endmodule : tb_top
